// *** hdl/hmec_counter.sv ***
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "hmec_cfg.svh"

module hmec_counter
  import hmec_pkg::*;
#(
  parameter int OCC_W = 6
) (
  input  wire logic             CLK_I,
  input  wire logic             ARST_N_I,
  input  wire logic             HSEL_I,
  input  wire logic [31:0]      HADDR_I,
  input  wire logic [1:0]       HTRANS_I,
  input  wire logic             HWRITE_I,
  input  wire logic [2:0]       HSIZE_I,
  input  wire logic [31:0]      HWDATA_I,
  input  wire logic             HREADY_I,
  output logic [31:0]           HRDATA_O,
  output logic                  HREADYOUT_O,
  output logic                  HRESP_O,
  output logic [31:0]           COUNT_O,
  input  wire logic             LOCAL_WR_REQ_I,
  input  wire logic [2:0]       TRK_FULL_I,
  input  wire logic [OCC_W-1:0] TRK_IOH_CNT_I,
  input  wire logic [OCC_W-1:0] TRK_REM_CNT_I,
  input  wire logic [OCC_W-1:0] TRK_LOC_CNT_I,
  input  wire logic [5:0]       TRK_CONFL_I,
  input  wire logic             CTBL_DEALLOC_I,
  input  wire logic [1:0]       CTBL_MAX_I,
  input  wire logic             BYPASS_I,
  input  wire logic             BYPASS_REMOTE_I,
  input  wire logic             BYPASS_WRITE_I,
  input  wire logic [2:0]       NQ_RD_FULL_I,
  input  wire logic [2:0]       NQ_WR_FULL_I,
  input  wire logic [2:0]       HQ_RD_FULL_I,
  input  wire logic [2:0]       HQ_WR_FULL_I,
  input  wire logic [2:0]       MC_RD_OUT_I,
  input  wire logic [2:0]       MC_WR_OUT_I
);

  hmec_state_t      s_q;
  hmec_state_t      s_d;
  logic [OCC_W-1:0] inc;
  logic             sel_ok;
  logic             addr_ok;
  logic             sw_cnt_wr;
  logic [2:0]       busy;
  logic [2:0]       confl;
  logic             bypass_ok;

  function automatic logic q3_ok(input logic [7:0] q);
    q3_ok = (q == `HMEC_Q_01) || (q == `HMEC_Q_02) || (q == `HMEC_Q_04);
  endfunction

  function automatic logic pick3(input logic [7:0] q, input logic [2:0] v);
    if (q == `HMEC_Q_01) begin
      pick3 = v[0];
    end else if (q == `HMEC_Q_02) begin
      pick3 = v[1];
    end else if (q == `HMEC_Q_04) begin
      pick3 = v[2];
    end else begin
      pick3 = 1'b0;
    end
  endfunction

  function automatic logic q6_ok(input logic [7:0] q);
    q6_ok = q3_ok(q) || (q == `HMEC_Q_08) || (q == `HMEC_Q_10) || (q == `HMEC_Q_20);
  endfunction

  // Low three codes pick the read side, high three the write side
  function automatic logic pick6(input logic [7:0] q, input logic [2:0] rd, input logic [2:0] wr);
    if (q == `HMEC_Q_08) begin
      pick6 = wr[0];
    end else if (q == `HMEC_Q_10) begin
      pick6 = wr[1];
    end else if (q == `HMEC_Q_20) begin
      pick6 = wr[2];
    end else begin
      pick6 = pick3(q, rd);
    end
  endfunction

  assign busy[0]   = (TRK_IOH_CNT_I != '0);
  assign busy[1]   = (TRK_REM_CNT_I != '0);
  assign busy[2]   = (TRK_LOC_CNT_I != '0);
  // Conflict count is two bits wide, so it cannot show more than three
  assign confl[0]  = (TRK_CONFL_I[1:0] >= `HMEC_CONFL_TWO);
  assign confl[1]  = (TRK_CONFL_I[3:2] >= `HMEC_CONFL_TWO);
  assign confl[2]  = (TRK_CONFL_I[5:4] >= `HMEC_CONFL_TWO);
  assign bypass_ok = BYPASS_I & ~(BYPASS_REMOTE_I & BYPASS_WRITE_I);

  always_comb begin
    inc    = '0;
    sel_ok = 1'b0;
    case (s_q.evt)
      `HMEC_EV_LOCAL_WR: begin
        sel_ok = (s_q.umask == `HMEC_Q_20);
        inc[0] = sel_ok & LOCAL_WR_REQ_I;
      end
      `HMEC_EV_TRK_FULL: begin
        sel_ok = q3_ok(s_q.umask);
        inc[0] = pick3(s_q.umask, TRK_FULL_I);
      end
      `HMEC_EV_TRK_BUSY: begin
        sel_ok = q3_ok(s_q.umask);
        inc[0] = pick3(s_q.umask, busy);
      end
      `HMEC_EV_TRK_OCC: begin
        sel_ok = q3_ok(s_q.umask);
        // Whole entry count each cycle, so the sum is entry-cycles
        if (s_q.umask == `HMEC_Q_01) begin
          inc = TRK_IOH_CNT_I;
        end else if (s_q.umask == `HMEC_Q_02) begin
          inc = TRK_REM_CNT_I;
        end else if (s_q.umask == `HMEC_Q_04) begin
          inc = TRK_LOC_CNT_I;
        end
      end
      `HMEC_EV_CTBL: begin
        sel_ok = (s_q.umask == `HMEC_Q_02) || (s_q.umask == `HMEC_Q_04);
        // Entries are seen only when they leave, once each
        if (s_q.umask == `HMEC_Q_02) begin
          inc[0] = CTBL_DEALLOC_I & (CTBL_MAX_I == `HMEC_CONFL_TWO);
        end else if (s_q.umask == `HMEC_Q_04) begin
          inc[0] = CTBL_DEALLOC_I & (CTBL_MAX_I == `HMEC_CONFL_THREE);
        end
      end
      `HMEC_EV_TRK_CONFL: begin
        sel_ok = q3_ok(s_q.umask);
        inc[0] = pick3(s_q.umask, confl);
      end
      `HMEC_EV_BYPASS: begin
        sel_ok = (s_q.umask == `HMEC_Q_01);
        inc[0] = sel_ok & bypass_ok;
      end
      `HMEC_EV_NQ_FULL: begin
        sel_ok = q6_ok(s_q.umask);
        inc[0] = pick6(s_q.umask, NQ_RD_FULL_I, NQ_WR_FULL_I);
      end
      `HMEC_EV_HQ_FULL: begin
        sel_ok = q6_ok(s_q.umask);
        inc[0] = pick6(s_q.umask, HQ_RD_FULL_I, HQ_WR_FULL_I);
      end
      `HMEC_EV_MC_OUT: begin
        sel_ok = q6_ok(s_q.umask);
        inc[0] = pick6(s_q.umask, MC_RD_OUT_I, MC_WR_OUT_I);
      end
      default: begin
        sel_ok = 1'b0;
      end
    endcase
    if (!sel_ok) begin
      inc = '0;
    end
  end

  assign addr_ok   = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign sw_cnt_wr = s_q.wr_pend & (s_q.wr_addr == `HMEC_OFS_COUNT);

  always_comb begin
    s_d         = s_q;
    s_d.ready   = 1'b1;
    s_d.resp    = 1'b0;
    // One step per uncore clock edge; no core clock reaches this block
    if (s_q.en) begin
      s_d.cnt = s_q.cnt + {{(32 - OCC_W){1'b0}}, inc};
    end
    // Software write to the count lands in the data phase and overrides the count step
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == `HMEC_OFS_EVTSEL) begin
        s_d.evt   = HWDATA_I[`HMEC_EVT_MSB:`HMEC_EVT_LSB];
        s_d.umask = HWDATA_I[`HMEC_UMASK_MSB:`HMEC_UMASK_LSB];
        s_d.en    = HWDATA_I[`HMEC_EN_BIT];
      end else if (s_q.wr_addr == `HMEC_OFS_COUNT) begin
        s_d.cnt = HWDATA_I;
      end
    end
    s_d.wr_pend = addr_ok & HWRITE_I;
    if (addr_ok) begin
      s_d.wr_addr = HADDR_I[7:0];
    end
    // Evtsel and count read data taken from the next state so a write just before is seen; status uses the current state
    if (addr_ok && !HWRITE_I) begin
      s_d.rdata = '0;
      if (HADDR_I[7:0] == `HMEC_OFS_EVTSEL) begin
        s_d.rdata[`HMEC_EVT_MSB:`HMEC_EVT_LSB]     = s_d.evt;
        s_d.rdata[`HMEC_UMASK_MSB:`HMEC_UMASK_LSB] = s_d.umask;
        s_d.rdata[`HMEC_EN_BIT]                    = s_d.en;
      end else if (HADDR_I[7:0] == `HMEC_OFS_COUNT) begin
        s_d.rdata = s_d.cnt;
      end else if (HADDR_I[7:0] == `HMEC_OFS_STATUS) begin
        s_d.rdata[`HMEC_ST_VALID_BIT]  = sel_ok;
        s_d.rdata[`HMEC_ST_ACTIVE_BIT] = sel_ok & s_q.en;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_q.evt     <= `HMEC_EVT_RST;
      s_q.umask   <= `HMEC_UMASK_RST;
      s_q.en      <= 1'b0;
      s_q.cnt     <= `HMEC_CNT_RST;
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= 8'h00;
      s_q.rdata   <= 32'h0000_0000;
      s_q.ready   <= 1'b1;
      s_q.resp    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign HRDATA_O    = s_q.rdata;
  assign HREADYOUT_O = s_q.ready;
  assign HRESP_O     = s_q.resp;
  assign COUNT_O     = s_q.cnt;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  logic step_ok;
  assign step_ok = s_q.en & ~sw_cnt_wr;

  chk_unlisted_hold: assert property (step_ok && !sel_ok |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter moved on unlisted selection");
  chk_local_write: assert property (step_ok && s_q.evt == 8'h20 && s_q.umask == 8'h20 && LOCAL_WR_REQ_I
    |=> s_q.cnt == $past(s_q.cnt) + 32'h1)
    else $error("local write not counted");
  chk_full_ioh: assert property (step_ok && s_q.evt == 8'h21 && s_q.umask == 8'h01
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_FULL_I[0])})
    else $error("io hub full cycles wrong");
  chk_busy_local: assert property (step_ok && s_q.evt == 8'h22 && s_q.umask == 8'h04
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_LOC_CNT_I != '0)})
    else $error("local busy cycles wrong");
  chk_occ_remote: assert property (step_ok && s_q.evt == 8'h23 && s_q.umask == 8'h02
    |=> s_q.cnt == $past(s_q.cnt) + {{(32 - OCC_W){1'b0}}, $past(TRK_REM_CNT_I)})
    else $error("remote occupancy not added");
  chk_ctbl_three: assert property (step_ok && s_q.evt == 8'h24 && s_q.umask == 8'h04
    && !(CTBL_DEALLOC_I && CTBL_MAX_I == 2'h3) |=> s_q.cnt == $past(s_q.cnt))
    else $error("three-way conflict miscounted");
  chk_confl_ioh: assert property (step_ok && s_q.evt == 8'h25 && s_q.umask == 8'h01
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_CONFL_I[1:0] >= 2'h2)})
    else $error("conflict cycles wrong");
  chk_remote_write: assert property (step_ok && s_q.evt == 8'h26 && s_q.umask == 8'h01
    && BYPASS_REMOTE_I && BYPASS_WRITE_I |=> s_q.cnt == $past(s_q.cnt))
    else $error("remote write counted as bypass");
  chk_isoc_wr2: assert property (step_ok && s_q.evt == 8'h28 && s_q.umask == 8'h20
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(HQ_WR_FULL_I[2])})
    else $error("isochronous write full wrong");
  chk_outst_wr0: assert property (step_ok && s_q.evt == 8'h29 && s_q.umask == 8'h08
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(MC_WR_OUT_I[0])})
    else $error("outstanding write cycles wrong");
  chk_bus_ready: assert property (HREADYOUT_O && !HRESP_O)
    else $error("slave stalled or errored");

  chk_full_remote: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_FULL && s_q.umask == `HMEC_Q_02
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_FULL_I[1])})
    else $error("remote full cycles wrong");
  chk_full_local: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_FULL && s_q.umask == `HMEC_Q_04
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_FULL_I[2])})
    else $error("local full cycles wrong");
  chk_busy_ioh: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_BUSY && s_q.umask == `HMEC_Q_01
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_IOH_CNT_I != '0)})
    else $error("io hub busy cycles wrong");
  chk_busy_remote: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_BUSY && s_q.umask == `HMEC_Q_02
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_REM_CNT_I != '0)})
    else $error("remote busy cycles wrong");
  chk_occ_ioh: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_OCC && s_q.umask == `HMEC_Q_01
    |=> s_q.cnt == $past(s_q.cnt) + {{(32 - OCC_W){1'b0}}, $past(TRK_IOH_CNT_I)})
    else $error("io hub occupancy not added");
  chk_occ_local: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_OCC && s_q.umask == `HMEC_Q_04
    |=> s_q.cnt == $past(s_q.cnt) + {{(32 - OCC_W){1'b0}}, $past(TRK_LOC_CNT_I)})
    else $error("local occupancy not added");
  chk_ctbl_two: assert property (step_ok && s_q.evt == `HMEC_EV_CTBL && s_q.umask == `HMEC_Q_02
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(CTBL_DEALLOC_I && CTBL_MAX_I == `HMEC_CONFL_TWO)})
    else $error("two-way conflict miscounted");
  chk_confl_remote: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_CONFL && s_q.umask == `HMEC_Q_02
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_CONFL_I[3:2] >= `HMEC_CONFL_TWO)})
    else $error("remote conflict cycles wrong");
  chk_confl_local: assert property (step_ok && s_q.evt == `HMEC_EV_TRK_CONFL && s_q.umask == `HMEC_Q_04
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(TRK_CONFL_I[5:4] >= `HMEC_CONFL_TWO)})
    else $error("local conflict cycles wrong");
  chk_bypass_count: assert property (step_ok && s_q.evt == `HMEC_EV_BYPASS && s_q.umask == `HMEC_Q_01
    && BYPASS_I && !BYPASS_REMOTE_I |=> s_q.cnt == $past(s_q.cnt) + 32'h1)
    else $error("local bypass not counted");
  chk_remote_read: assert property (step_ok && s_q.evt == `HMEC_EV_BYPASS && s_q.umask == `HMEC_Q_01
    && BYPASS_I && BYPASS_REMOTE_I && !BYPASS_WRITE_I |=> s_q.cnt == $past(s_q.cnt) + 32'h1)
    else $error("remote read bypass not counted");
  chk_normal_rd1: assert property (step_ok && s_q.evt == `HMEC_EV_NQ_FULL && s_q.umask == `HMEC_Q_02
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(NQ_RD_FULL_I[1])})
    else $error("normal read full wrong");
  chk_normal_wr0: assert property (step_ok && s_q.evt == `HMEC_EV_NQ_FULL && s_q.umask == `HMEC_Q_08
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(NQ_WR_FULL_I[0])})
    else $error("normal write full wrong");
  chk_normal_wr2: assert property (step_ok && s_q.evt == `HMEC_EV_NQ_FULL && s_q.umask == `HMEC_Q_20
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(NQ_WR_FULL_I[2])})
    else $error("normal write full wrong");
  chk_isoc_rd0: assert property (step_ok && s_q.evt == `HMEC_EV_HQ_FULL && s_q.umask == `HMEC_Q_01
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(HQ_RD_FULL_I[0])})
    else $error("isochronous read full wrong");
  chk_isoc_rd2: assert property (step_ok && s_q.evt == `HMEC_EV_HQ_FULL && s_q.umask == `HMEC_Q_04
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(HQ_RD_FULL_I[2])})
    else $error("isochronous read full wrong");
  chk_outst_rd0: assert property (step_ok && s_q.evt == `HMEC_EV_MC_OUT && s_q.umask == `HMEC_Q_01
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(MC_RD_OUT_I[0])})
    else $error("outstanding read cycles wrong");
  chk_outst_rd2: assert property (step_ok && s_q.evt == `HMEC_EV_MC_OUT && s_q.umask == `HMEC_Q_04
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(MC_RD_OUT_I[2])})
    else $error("outstanding read cycles wrong");
  chk_outst_wr1: assert property (step_ok && s_q.evt == `HMEC_EV_MC_OUT && s_q.umask == `HMEC_Q_10
    |=> s_q.cnt == $past(s_q.cnt) + {31'h0, $past(MC_WR_OUT_I[1])})
    else $error("outstanding write cycles wrong");
  // Cycle events may add at most one per uncore edge; wrap is modulo so the difference still holds
  chk_one_step: assert property (step_ok && s_q.evt != `HMEC_EV_TRK_OCC
    |=> (s_q.cnt - $past(s_q.cnt)) <= 32'h1)
    else $error("more than one step per cycle");

  cov_occ_run: cover property (step_ok && s_q.evt == 8'h23 && inc != '0 ##1 inc != '0);
  cov_ctbl_hit: cover property (step_ok && s_q.evt == 8'h24 && inc[0]);
  cov_wr_rd: cover property (addr_ok && HWRITE_I ##1 addr_ok && !HWRITE_I);
  cov_bypass_block: cover property (step_ok && s_q.evt == `HMEC_EV_BYPASS
    && BYPASS_I && BYPASS_REMOTE_I && BYPASS_WRITE_I);
  cov_cnt_wrap: cover property (step_ok && s_q.cnt[31] ##1 !s_q.cnt[31]);

endmodule

// *** common/hmec_cfg.svh ***
`ifndef HMEC_CFG_SVH
`define HMEC_CFG_SVH

`define HMEC_OFS_EVTSEL     8'h00
`define HMEC_OFS_COUNT      8'h04
`define HMEC_OFS_STATUS     8'h08

`define HMEC_EVT_LSB        0
`define HMEC_EVT_MSB        7
`define HMEC_UMASK_LSB      8
`define HMEC_UMASK_MSB      15
`define HMEC_EN_BIT         16
`define HMEC_ST_VALID_BIT   0
`define HMEC_ST_ACTIVE_BIT  1

`define HMEC_EVT_RST        8'h00
`define HMEC_UMASK_RST      8'h00
`define HMEC_CNT_RST        32'h0000_0000

`define HMEC_EV_LOCAL_WR    8'h20
`define HMEC_EV_TRK_FULL    8'h21
`define HMEC_EV_TRK_BUSY    8'h22
`define HMEC_EV_TRK_OCC     8'h23
`define HMEC_EV_CTBL        8'h24
`define HMEC_EV_TRK_CONFL   8'h25
`define HMEC_EV_BYPASS      8'h26
`define HMEC_EV_NQ_FULL     8'h27
`define HMEC_EV_HQ_FULL     8'h28
`define HMEC_EV_MC_OUT      8'h29

`define HMEC_Q_01           8'h01
`define HMEC_Q_02           8'h02
`define HMEC_Q_04           8'h04
`define HMEC_Q_08           8'h08
`define HMEC_Q_10           8'h10
`define HMEC_Q_20           8'h20

`define HMEC_CONFL_TWO      2'h2
`define HMEC_CONFL_THREE    2'h3

`endif

// *** common/hmec_pkg.sv ***
package hmec_pkg;

  typedef struct packed {
    logic [7:0]  evt;
    logic [7:0]  umask;
    logic        en;
    logic [31:0] cnt;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
  } hmec_state_t;

endpackage

// *** tb/hmec_partner.sv ***
`timescale 1ns/100ps
// Far side: trackers, conflict table, bypass path and channel queues, driven from a bench pattern
module hmec_partner #(
  parameter int OCC_W = 6
) (
  input  wire logic [5:0]       pat_i,
  input  wire logic [1:0]       sel_i,
  output logic                  lwr_o,
  output logic [2:0]            full_o,
  output logic [OCC_W-1:0]      c0_o,
  output logic [OCC_W-1:0]      c1_o,
  output logic [OCC_W-1:0]      c2_o,
  output logic [5:0]            confl_o,
  output logic                  dealloc_o,
  output logic [1:0]            cmax_o,
  output logic                  byp_o,
  output logic                  brem_o,
  output logic                  bwr_o,
  output logic [5:0]            nq_o,
  output logic [5:0]            hq_o,
  output logic [5:0]            mc_o
);
  logic [5:0] swp;
  always_comb begin
    swp       = {pat_i[2:0], pat_i[5:3]};
    lwr_o     = pat_i[5];
    full_o    = pat_i[2:0];
    c0_o      = pat_i[0] ? OCC_W'(5) : '0;
    c1_o      = pat_i[1] ? OCC_W'(6) : '0;
    c2_o      = pat_i[2] ? OCC_W'(7) : '0;
    // One request alone is no conflict; never more than three
    confl_o   = {pat_i[2] ? 2'h2 : 2'h1, pat_i[1] ? 2'h3 : 2'h1, pat_i[0] ? 2'h2 : 2'h1};
    dealloc_o = pat_i[1] | pat_i[2];
    cmax_o    = pat_i[2] ? 2'h3 : 2'h2;
    // A remote write bypass whenever pattern bits 0, 3 and 4 are all set, as in the illegal case and several inverted phases
    byp_o     = pat_i[0];
    brem_o    = pat_i[3];
    bwr_o     = pat_i[4];
    // Unselected queue families see the halves swapped, so a family mix-up shows
    nq_o      = (sel_i == 2'h1) ? pat_i : swp;
    hq_o      = (sel_i == 2'h2) ? pat_i : swp;
    mc_o      = (sel_i == 2'h3) ? pat_i : swp;
  end
endmodule

// *** tb/home_and_memctl_event_counter_test.sv ***
`timescale 1ns/100ps
`include "hmec_cfg.svh"
module home_and_memctl_event_counter_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [5:0]  pat = 6'h0;
  logic [1:0]  sel = 2'h0;
  wire  [31:0] hrdata, count;
  wire         hready, hresp, lwr, dealloc, byp, brem, bwr;
  wire  [2:0]  full;
  wire  [5:0]  c0, c1, c2, confl, nq, hq, mc;
  wire  [1:0]  cmax;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // {event, qualifier, pattern with bit 6 = unlisted, weight per cycle}
  logic [31:0] tbl [41] = '{32'h20202001, 32'h21010101, 32'h21020201, 32'h21040401, 32'h22010101,
    32'h22020201, 32'h22040401, 32'h23010105, 32'h23020206, 32'h23040407, 32'h24020201, 32'h24040401,
    32'h25010101, 32'h25020201, 32'h25040401, 32'h26010101, 32'h26011900, 32'h26011101, 32'h26010901,
    32'h27010101, 32'h27020201, 32'h27040401, 32'h27080801, 32'h27101001, 32'h27202001,
    32'h28010101, 32'h28020201, 32'h28040401, 32'h28080801, 32'h28101001, 32'h28202001,
    32'h29010101, 32'h29020201, 32'h29040401, 32'h29080801, 32'h29101001, 32'h29202001,
    32'h20017f00, 32'h24017f00, 32'h2a017f00, 32'h21037f00};

  always #5 clk = ~clk;

  hmec_counter dut (.CLK_I(clk), .ARST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .COUNT_O(count), .LOCAL_WR_REQ_I(lwr), .TRK_FULL_I(full),
    .TRK_IOH_CNT_I(c0), .TRK_REM_CNT_I(c1), .TRK_LOC_CNT_I(c2), .TRK_CONFL_I(confl),
    .CTBL_DEALLOC_I(dealloc), .CTBL_MAX_I(cmax), .BYPASS_I(byp), .BYPASS_REMOTE_I(brem),
    .BYPASS_WRITE_I(bwr), .NQ_RD_FULL_I(nq[2:0]), .NQ_WR_FULL_I(nq[5:3]), .HQ_RD_FULL_I(hq[2:0]),
    .HQ_WR_FULL_I(hq[5:3]), .MC_RD_OUT_I(mc[2:0]), .MC_WR_OUT_I(mc[5:3]));

  hmec_partner far (.pat_i(pat), .sel_i(sel), .lwr_o(lwr), .full_o(full), .c0_o(c0), .c1_o(c1),
    .c2_o(c2), .confl_o(confl), .dealloc_o(dealloc), .cmax_o(cmax), .byp_o(byp), .brem_o(brem),
    .bwr_o(bwr), .nq_o(nq), .hq_o(hq), .mc_o(mc));

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Single word transfer; waits on ready without assuming a latency
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(n, exp, v);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Five cycles on the chosen source, then five on every other one
  task automatic run(input logic [31:0] e, input logic [31:0] base);
    logic [31:0] exp;
    exp = base + 32'h5 * e[7:0];
    wr(`HMEC_OFS_EVTSEL, {15'h0, 1'b1, e[23:16], e[31:24]});
    rd(`HMEC_OFS_STATUS, e[14] ? 32'h0 : 32'h3, "status");
    wr(`HMEC_OFS_COUNT, base);
    @(posedge clk);
    sel <= (e[31:24] > 8'h26 && e[31:24] < 8'h2a) ? 2'(e[31:24] - 8'h26) : 2'h0;
    pat <= e[13:8];
    repeat (5) @(posedge clk);
    pat <= ~e[13:8];
    repeat (5) @(posedge clk);
    pat <= 6'h0;
    rd(`HMEC_OFS_COUNT, exp, "count");
    check("count_port", exp, count);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`HMEC_OFS_EVTSEL, 32'h0, "evtsel_rst");
    rd(`HMEC_OFS_COUNT, `HMEC_CNT_RST, "count_rst");
    rd(8'h10, 32'h0, "unmapped");
    for (int i = 0; i < 41; i++) run(tbl[i], 32'h0);
    run(32'h23040407, 32'hffff_fffe);
    wr(`HMEC_OFS_STATUS, 32'h0);
    rd(`HMEC_OFS_STATUS, 32'h3, "status_ro");
    // Mid-run reset must clear the live count and the selection
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    check("count_mid_rst", `HMEC_CNT_RST, count);
    rd(`HMEC_OFS_EVTSEL, 32'h0, "evtsel_mid_rst");
    rd(`HMEC_OFS_STATUS, 32'h0, "status_mid_rst");
    final_report();
  end
endmodule
